// ==== hw/sir_responder.sv ====
// Inquiry responder: decodes six-byte commands, streams inquiry data, AXI4-Lite registers.
// Assumes commands and data-in from logic on clk; one AXI4-Lite master.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sir_consts.svh"

// Overview of operation
// - Byte 0 code 12h is recognised as the inquiry request.
// - Select bit zero and page zero returns the standard data block.
// - Select bit zero with nonzero page ends with illegal request, invalid field.
// - Select bit one returns the supported page list for page 00h; other listed pages return a four-byte header with zero page length.
// - Zero allocation sends nothing; otherwise send the lesser of available and allocation.
// - A pending unit attention stays pending across an inquiry.
// - Inquiry runs at once and never goes to the command queue.
// - Byte 0 is zero for a present unit, qualifier 011b if absent.
// - Invalid unit: every command except inquiry and request sense gets check condition.
// - Standard byte 2 is version 7; byte 3 format 2 with hierarchical bit.
// - Standard byte 4 holds additional length 159.
// - Byte 6 port bit tells port A or B; multiport one, enclosure zero.
// - Byte 1 removable bit and rest are zero.
// - Normal ACA bit reads zero; a set NACA control bit is refused.
// - Data fixed except the revision level, loaded after a microcode download.
// - With the medium unavailable the data may be incomplete.
// - Supported page list is in ascending order.
module sir_responder #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Command in
  input  wire logic          cmd_valid,
  input  wire logic [47:0]   cmd_cdb,
  input  wire logic          cmd_port_b,
  input  wire logic          cmd_lun_ok,
  input  wire logic          cmd_ua_pending,
  output logic               cmd_ready,
  // Queue hand-off
  output logic               fwd_valid,
  // Data in stream
  output logic               din_valid,
  output logic [7:0]         din_data,
  output logic               din_last,
  input  wire logic          din_ready,
  // Completion status
  output logic               sts_valid,
  output logic               sts_check,
  output logic [3:0]         sts_key,
  output logic [7:0]         sts_asc,
  output logic               sts_ua_kept,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);

  if (ADDR_W < 4) begin : g_chk
    $error("ADDR_W must be at least 4");
  end

  // Command fields
  logic [7:0]  op;
  logic        evpd;
  logic        cmddt;
  logic [7:0]  page;
  logic [15:0] alloc;
  logic        naca;
  assign op    = cmd_cdb[47:40];
  assign evpd  = cmd_cdb[32];
  assign cmddt = cmd_cdb[33];
  assign page  = cmd_cdb[31:24];
  assign alloc = {cmd_cdb[23:16], cmd_cdb[15:8]};
  assign naca  = cmd_cdb[`SIR_NACA_BIT];

  // Engine state
  sir_pkg::sir_state_type state, next_state;
  logic        l_evpd, l_port_b, l_lun_ok;
  logic [7:0]  l_page, idx, tot;
  logic        next_l_evpd, next_l_port_b, next_l_lun_ok;
  logic [7:0]  next_l_page, next_idx, next_tot;
  logic        next_cmd_ready, next_fwd_valid, next_din_valid, next_din_last;
  logic [7:0]  next_din_data;
  logic        next_sts_valid, next_sts_check, next_sts_ua_kept;
  logic [3:0]  next_sts_key;
  logic [7:0]  next_sts_asc;
  logic [15:0] cnt, next_cnt;
  logic        last_check, next_last_check;

  // Registers
  logic [31:0] rev, next_rev;
  logic        media_ok, next_media_ok;

  // Byte source
  logic        s_evpd, s_port_b, s_lun_ok, page_ok;
  logic [7:0]  s_page, s_idx, s_data, avail;
  logic        accept, hs;
  assign accept   = cmd_valid && cmd_ready;
  assign hs       = din_valid && din_ready;
  assign s_evpd   = (state == sir_pkg::SIR_IDLE) ? evpd : l_evpd;
  assign s_page   = (state == sir_pkg::SIR_IDLE) ? page : l_page;
  assign s_port_b = (state == sir_pkg::SIR_IDLE) ? cmd_port_b : l_port_b;
  assign s_lun_ok = (state == sir_pkg::SIR_IDLE) ? cmd_lun_ok : l_lun_ok;
  assign s_idx    = (state != sir_pkg::SIR_SEND) ? 8'h00 : (hs ? idx + 8'h01 : idx);

  sir_byte_src u_src (
    .idx      (s_idx),
    .evpd     (s_evpd),
    .page     (s_page),
    .lun_ok   (s_lun_ok),
    .port_b   (s_port_b),
    .media_ok (media_ok),
    .rev      (rev),
    .data     (s_data),
    .avail    (avail),
    .page_ok  (page_ok)
  );

  always_comb begin
    next_state       = state;
    next_l_evpd      = l_evpd;
    next_l_page      = l_page;
    next_l_port_b    = l_port_b;
    next_l_lun_ok    = l_lun_ok;
    next_idx         = idx;
    next_tot         = tot;
    next_fwd_valid   = 1'b0;
    next_din_valid   = din_valid;
    next_din_data    = din_data;
    next_din_last    = din_last;
    next_sts_valid   = 1'b0;
    next_sts_check   = sts_check;
    next_sts_key     = sts_key;
    next_sts_asc     = sts_asc;
    next_sts_ua_kept = sts_ua_kept;
    next_cnt         = cnt;
    next_last_check  = last_check;
    case (state)
      sir_pkg::SIR_IDLE: begin
        if (accept && op == `SIR_OP_INQUIRY) begin
          next_l_evpd      = evpd;
          next_l_page      = page;
          next_l_port_b    = cmd_port_b;
          next_l_lun_ok    = cmd_lun_ok;
          next_sts_ua_kept = cmd_ua_pending;
          next_cnt         = cnt + 16'h0001;
          next_sts_key     = 4'h0;
          next_sts_asc     = 8'h00;
          next_sts_check   = 1'b0;
          next_tot         = (alloc < 16'(avail)) ? alloc[7:0] : avail;
          next_idx         = 8'h00;
          if (cmddt || naca || (!evpd && page != 8'h00) || (evpd && !page_ok)) begin
            next_sts_valid = 1'b1;
            next_sts_check = 1'b1;
            next_sts_key   = `SIR_KEY_ILLEGAL;
            next_sts_asc   = `SIR_ASC_BADFIELD;
          end else if (alloc == 16'h0000) begin
            next_sts_valid = 1'b1;
          end else begin
            next_state     = sir_pkg::SIR_SEND;
            next_din_valid = 1'b1;
            next_din_data  = s_data;
            next_din_last  = (next_tot == 8'h01);
          end
          next_last_check = next_sts_check;
        end else if (accept) begin
          if (!cmd_lun_ok && op != `SIR_OP_REQSENSE) begin
            next_sts_valid   = 1'b1;
            next_sts_check   = 1'b1;
            next_sts_key     = `SIR_KEY_ILLEGAL;
            next_sts_asc     = `SIR_ASC_BADLUN;
            next_sts_ua_kept = cmd_ua_pending;
          end else begin
            next_fwd_valid = 1'b1;
          end
        end
      end
      sir_pkg::SIR_SEND: begin
        if (hs) begin
          next_idx = idx + 8'h01;
          if (din_last) begin
            next_state     = sir_pkg::SIR_IDLE;
            next_din_valid = 1'b0;
            next_din_last  = 1'b0;
            next_sts_valid = 1'b1;
          end else begin
            next_din_data = s_data;
            next_din_last = (idx + 8'h02 == tot);
          end
        end
      end
      default: next_state = sir_pkg::SIR_IDLE;
    endcase
    next_cmd_ready = (next_state == sir_pkg::SIR_IDLE);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state       <= sir_pkg::SIR_IDLE;
      l_evpd      <= 1'b0;
      l_page      <= 8'h00;
      l_port_b    <= 1'b0;
      l_lun_ok    <= 1'b0;
      idx         <= 8'h00;
      tot         <= 8'h00;
      cmd_ready   <= 1'b0;
      fwd_valid   <= 1'b0;
      din_valid   <= 1'b0;
      din_data    <= 8'h00;
      din_last    <= 1'b0;
      sts_valid   <= 1'b0;
      sts_check   <= 1'b0;
      sts_key     <= 4'h0;
      sts_asc     <= 8'h00;
      sts_ua_kept <= 1'b0;
      cnt         <= 16'h0000;
      last_check  <= 1'b0;
    end else begin
      state       <= next_state;
      l_evpd      <= next_l_evpd;
      l_page      <= next_l_page;
      l_port_b    <= next_l_port_b;
      l_lun_ok    <= next_l_lun_ok;
      idx         <= next_idx;
      tot         <= next_tot;
      cmd_ready   <= next_cmd_ready;
      fwd_valid   <= next_fwd_valid;
      din_valid   <= next_din_valid;
      din_data    <= next_din_data;
      din_last    <= next_din_last;
      sts_valid   <= next_sts_valid;
      sts_check   <= next_sts_check;
      sts_key     <= next_sts_key;
      sts_asc     <= next_sts_asc;
      sts_ua_kept <= next_sts_ua_kept;
      cnt         <= next_cnt;
      last_check  <= next_last_check;
    end
  end

  // AXI4-Lite slave
  logic              aw_held, w_held, next_aw_held, next_w_held;
  logic [ADDR_W-1:0] awaddr, next_awaddr;
  logic [31:0]       wdata, next_wdata;
  logic [3:0]        wstrb, next_wstrb;
  logic              do_wr, wr_rev;
  logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata;
  logic [ADDR_W-1:0] wa, ra;
  assign wa     = {awaddr[ADDR_W-1:2], 2'b00};
  assign ra     = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign do_wr  = aw_held && w_held && !s_axi_bvalid;
  assign wr_rev = do_wr && wa == ADDR_W'(`SIR_OFF_REV);

  for (genvar i = 0; i < 4; i++) begin : g_rev
    assign next_rev[8*i +: 8] = (wr_rev && wstrb[i]) ? wdata[8*i +: 8] : rev[8*i +: 8];
  end

  always_comb begin
    next_aw_held  = aw_held || (s_axi_awvalid && s_axi_awready);
    next_w_held   = w_held || (s_axi_wvalid && s_axi_wready);
    next_awaddr   = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr;
    next_wdata    = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata;
    next_wstrb    = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb;
    next_bvalid   = s_axi_bvalid && !s_axi_bready;
    next_bresp    = s_axi_bresp;
    next_media_ok = media_ok;
    if (do_wr) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = 2'b00;
      if (wa == ADDR_W'(`SIR_OFF_CTRL)) begin
        if (wstrb[0]) begin
          next_media_ok = wdata[0];
        end
      end else if (wa != ADDR_W'(`SIR_OFF_REV)) begin
        next_bresp = 2'b10;
      end
    end
    next_awready = !next_aw_held;
    next_wready  = !next_w_held;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'b00;
      if (ra == ADDR_W'(`SIR_OFF_REV)) begin
        next_rdata = rev;
      end else if (ra == ADDR_W'(`SIR_OFF_CTRL)) begin
        next_rdata = {31'h0, media_ok};
      end else if (ra == ADDR_W'(`SIR_OFF_STATUS)) begin
        next_rdata = {14'h0, last_check, l_evpd, l_page, 7'h0, din_valid};
      end else if (ra == ADDR_W'(`SIR_OFF_COUNT)) begin
        next_rdata = {16'h0, cnt};
      end else begin
        next_rdata = 32'h0;
        next_rresp = 2'b10;
      end
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      awaddr        <= '0;
      wdata         <= 32'h0;
      wstrb         <= 4'h0;
      rev           <= `SIR_REV_RST;
      media_ok      <= `SIR_CTRL_RST;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      awaddr        <= next_awaddr;
      wdata         <= next_wdata;
      wstrb         <= next_wstrb;
      rev           <= next_rev;
      media_ok      <= next_media_ok;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // Checks
  logic inq_ok;
  assign inq_ok = accept && op == `SIR_OP_INQUIRY && !cmddt && !naca;

  a_inq_starts: assert property (@(posedge clk) disable iff (!nrst)
    inq_ok && !evpd && page == 8'h00 && alloc != 16'h0000 |=> din_valid && !cmd_ready)
    else $error("inquiry did not start data");
  a_byte0_lun: assert property (@(posedge clk) disable iff (!nrst)
    inq_ok && !evpd && page == 8'h00 && alloc != 16'h0000
    |=> din_data == (l_lun_ok ? 8'h00 : 8'h60))
    else $error("byte 0 wrong");
  a_bad_page: assert property (@(posedge clk) disable iff (!nrst)
    inq_ok && !evpd && page != 8'h00
    |=> sts_valid && sts_check && sts_key == 4'h5 && sts_asc == 8'h24 && !din_valid)
    else $error("nonzero page not refused");
  a_zero_alloc: assert property (@(posedge clk) disable iff (!nrst)
    inq_ok && alloc == 16'h0000 |=> sts_valid && !din_valid)
    else $error("data sent for zero length");
  a_last_count: assert property (@(posedge clk) disable iff (!nrst)
    hs && din_last |-> idx + 8'h01 == tot ##1 sts_valid && !sts_check)
    else $error("transfer length wrong");
  a_not_queued: assert property (@(posedge clk) disable iff (!nrst)
    accept && op == `SIR_OP_INQUIRY |=> !fwd_valid)
    else $error("inquiry sent to queue");
  a_bad_lun: assert property (@(posedge clk) disable iff (!nrst)
    accept && !cmd_lun_ok && op != `SIR_OP_INQUIRY && op != `SIR_OP_REQSENSE
    |=> sts_check && sts_asc == 8'h25 && !fwd_valid)
    else $error("bad unit not refused");
  a_version: assert property (@(posedge clk) disable iff (!nrst)
    din_valid && !l_evpd && idx == 8'h02 |-> din_data == 8'h07)
    else $error("version byte wrong");
  a_ua_kept: assert property (@(posedge clk) disable iff (!nrst)
    inq_ok && cmd_ua_pending |=> sts_ua_kept)
    else $error("unit attention lost");
  a_data_hold: assert property (@(posedge clk) disable iff (!nrst)
    din_valid && !din_ready |=> din_valid && $stable(din_data))
    else $error("data changed while stalled");

  c_std_done: cover property (@(posedge clk) disable iff (!nrst)
    hs && din_last && !l_evpd && idx == 8'hA3);
  c_list_page: cover property (@(posedge clk) disable iff (!nrst)
    hs && din_last && l_evpd && l_page == 8'h00);
  c_refused: cover property (@(posedge clk) disable iff (!nrst) sts_valid && sts_check);
  c_forward: cover property (@(posedge clk) disable iff (!nrst) fwd_valid);

endmodule
`default_nettype wire

// ==== hw/sir_consts.svh ====
// Constants of the inquiry responder: offsets, fields, codes, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef SIR_CONSTS_SVH
`define SIR_CONSTS_SVH

// Register byte offsets
`define SIR_OFF_REV       8'h00
`define SIR_OFF_CTRL      8'h04
`define SIR_OFF_STATUS    8'h08
`define SIR_OFF_COUNT     8'h0C

// Reset values
`define SIR_REV_RST       32'h30303031
`define SIR_CTRL_RST      1'h1

// Command codes and fields
`define SIR_OP_INQUIRY    8'h12
`define SIR_OP_REQSENSE   8'h03
`define SIR_NACA_BIT      2

// Sense answers
`define SIR_KEY_ILLEGAL   4'h5
`define SIR_ASC_BADFIELD  8'h24
`define SIR_ASC_BADLUN    8'h25

// Standard data layout
`define SIR_STD_LEN       8'hA4
`define SIR_VERSION       8'h07
`define SIR_FMT_BYTE      8'h12
`define SIR_ADD_LEN       8'h9F
`define SIR_PROT_BYTE     8'h01
`define SIR_QUEUE_BYTE    8'h02
`define SIR_QUAL_ABSENT   3'h3
`define SIR_B_VENDOR      8
`define SIR_B_PRODUCT     16
`define SIR_B_REV         32
`define SIR_B_SERIAL      36
`define SIR_B_RSV1        44
`define SIR_B_NOTICE      96
`define SIR_B_RSV2        146
`define SIR_ASCII_BLANK   8'h20

// Vital product data
`define SIR_VPD_HDR       8'h04
`define SIR_VPD_LIST_N    8'h11

`endif

// ==== hw/sir_pkg.sv ====
// Types shared by the inquiry responder files.
// Assumes nothing of its surroundings.
package sir_pkg;
  typedef enum logic {SIR_IDLE, SIR_SEND} sir_state_type;
endpackage

// ==== hw/sir_byte_src.sv ====
// Byte source: returns one byte of inquiry data for a given index.
// Assumes a purely combinational use by the inquiry engine.
`timescale 1ns/1ps
`default_nettype none
`include "sir_consts.svh"

module sir_byte_src #(
  // Identity strings; values are arbitrary
  parameter logic [63:0]  VENDOR_ID  = "VNDRNAME",
  parameter logic [127:0] PRODUCT_ID = "DISK TARGET 0001",
  parameter logic [63:0]  SERIAL_NO  = "SN000001",
  parameter logic [399:0] NOTICE     = "NOTICE TEXT"
) (
  // Selection
  input  wire logic [7:0]  idx,
  input  wire logic        evpd,
  input  wire logic [7:0]  page,
  input  wire logic        lun_ok,
  input  wire logic        port_b,
  input  wire logic        media_ok,
  input  wire logic [31:0] rev,
  // Result
  output logic [7:0]       data,
  output logic [7:0]       avail,
  output logic             page_ok
);

  function automatic logic [7:0] list_code(input logic [7:0] i);
    case (i)
      8'h00:   list_code = 8'h00;
      8'h01:   list_code = 8'h03;
      8'h02:   list_code = 8'h80;
      8'h03:   list_code = 8'h83;
      8'h04:   list_code = 8'h86;
      8'h05:   list_code = 8'h87;
      8'h06:   list_code = 8'h88;
      8'h07:   list_code = 8'h8A;
      8'h08:   list_code = 8'h8D;
      8'h09:   list_code = 8'h90;
      8'h0A:   list_code = 8'h91;
      8'h0B:   list_code = 8'hB0;
      8'h0C:   list_code = 8'hB1;
      8'h0D:   list_code = 8'hB2;
      8'h0E:   list_code = 8'hD1;
      8'h0F:   list_code = 8'hD2;
      8'h10:   list_code = 8'hD9;
      default: list_code = 8'hFF;
    endcase
  endfunction

  logic [7:0] byte0;
  int         off;

  always_comb begin
    off     = 0;
    data    = 8'h00;
    page_ok = 1'b0;
    byte0   = lun_ok ? 8'h00 : {`SIR_QUAL_ABSENT, 5'h00};
    for (int i = 0; i < 17; i++) begin
      if (list_code(8'(i)) == page) begin
        page_ok = 1'b1;
      end
    end
    if (!evpd) begin
      avail = `SIR_STD_LEN;
    end else if (page == 8'h00) begin
      avail = `SIR_VPD_HDR + `SIR_VPD_LIST_N;
    end else begin
      avail = `SIR_VPD_HDR;
    end
    if (evpd) begin
      if (idx == 8'h00) begin
        data = byte0;
      end else if (idx == 8'h01) begin
        data = page;
      end else if (idx == 8'h03) begin
        data = (page == 8'h00) ? `SIR_VPD_LIST_N : 8'h00;
      end else if (page == 8'h00 && idx >= `SIR_VPD_HDR) begin
        data = list_code(idx - `SIR_VPD_HDR);
      end
    end else begin
      case (idx)
        8'h00:   data = byte0;
        8'h01:   data = 8'h00;
        8'h02:   data = `SIR_VERSION;
        8'h03:   data = `SIR_FMT_BYTE;
        8'h04:   data = `SIR_ADD_LEN;
        8'h05:   data = `SIR_PROT_BYTE;
        8'h06:   data = {2'b00, port_b, 1'b1, 4'h0};
        8'h07:   data = `SIR_QUEUE_BYTE;
        default: begin
          if (idx < `SIR_B_PRODUCT) begin
            off  = int'(idx) - `SIR_B_VENDOR;
            data = VENDOR_ID[8*(7-off) +: 8];
          end else if (idx < `SIR_B_REV) begin
            off  = int'(idx) - `SIR_B_PRODUCT;
            data = PRODUCT_ID[8*(15-off) +: 8];
          end else if (idx < `SIR_B_SERIAL) begin
            off  = int'(idx) - `SIR_B_REV;
            data = rev[8*(3-off) +: 8];
          end else if (idx < `SIR_B_RSV1) begin
            off  = int'(idx) - `SIR_B_SERIAL;
            data = media_ok ? SERIAL_NO[8*(7-off) +: 8] : `SIR_ASCII_BLANK;
          end else if (idx >= `SIR_B_NOTICE && idx < `SIR_B_RSV2) begin
            off  = int'(idx) - `SIR_B_NOTICE;
            data = NOTICE[8*(49-off) +: 8];
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== tb/sir_initiator.sv ====
// Initiator model: sink of the data-in stream, prompt or stalling.
// Assumes clk and nrst of the responder; slow selects random stalls.
`timescale 1ns/1ps
`default_nettype none
module sir_initiator (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Mode
  input  wire logic slow,
  // Data-in handshake
  output logic      din_ready
);
  // Takes every byte at once, or on random cycles when slow
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) din_ready <= 1'b0;
    else din_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
  end
endmodule
`default_nettype wire

// ==== tb/sir_responder_test.sv ====
// Bench of the inquiry responder: commands, data-in stream, registers.
// Assumes the initiator model as data-in sink; random seed fixed at 17.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, a, e); end end
module sir_responder_test;
  logic        clk, nrst, slow, cmd_valid, cmd_port_b, cmd_lun_ok, cmd_ua_pending, cmd_ready;
  logic        fwd_valid, din_valid, din_last, din_ready, sts_valid, sts_check, sts_ua_kept;
  logic [47:0] cmd_cdb;
  logic [7:0]  din_data, sts_asc, s_axi_awaddr, s_axi_araddr;
  logic [3:0]  sts_key, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, lst, fwd;
  logic [7:0]  q[$];
  int          bad_count, check_count;
  localparam logic [63:0] STD_HEAD = 64'h0000_0712_9F01_1002;
  sir_responder dut_u (.clk, .nrst, .cmd_valid, .cmd_cdb, .cmd_port_b, .cmd_lun_ok,
    .cmd_ua_pending, .cmd_ready, .fwd_valid, .din_valid, .din_data, .din_last, .din_ready,
    .sts_valid, .sts_check, .sts_key, .sts_asc, .sts_ua_kept, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sir_initiator peer_u (.clk, .nrst, .slow, .din_ready);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [47:0] cdb(input logic [7:0] op, input logic ev,
    input logic [7:0] pg, input logic [15:0] al, input logic [7:0] ctl);
    return {op, 7'h00, ev, pg, al, ctl};
  endfunction
  function automatic int exp_len(input logic ev, input logic [7:0] pg, input logic [15:0] al);
    int av;
    av = !ev ? 164 : (pg == 8'h00 ? 21 : 4);
    return (int'(al) < av) ? int'(al) : av;
  endfunction
  function automatic logic [7:0] exp_std(input int i, input logic pb);
    if (i >= 8) return 8'h00;
    return STD_HEAD[63-8*i -: 8] | ((i == 6) ? {2'b00, pb, 5'h00} : 8'h00);
  endfunction
  task automatic cmd(input logic [47:0] c, input logic pb, input logic lo, input logic ua);
    q.delete();
    fwd = 1'b0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_cdb <= c;
    cmd_port_b <= pb;
    cmd_lun_ok <= lo;
    cmd_ua_pending <= ua;
    do @(posedge clk); while (!cmd_ready);
    cmd_valid <= 1'b0;
    repeat (900) begin
      @(posedge clk);
      if (din_valid && din_ready) begin
        q.push_back(din_data);
        lst = din_last;
      end
      fwd = fwd_valid;
      if (sts_valid || fwd_valid) break;
    end
  endtask
  task automatic inq(input logic ev, input logic [7:0] pg, input logic [15:0] al, input logic pb);
    cmd(cdb(8'h12, ev, pg, al, 8'h00), pb, 1'b1, 1'b0);
    `CHK(q.size(), exp_len(ev, pg, al))
    `CHK({fwd, sts_check}, 2'b00)
    if (q.size() > 0) `CHK(lst, 1'b1)
    if (ev && q.size() > 1) `CHK({q[0], q[1]}, {8'h00, pg})
    for (int i = 0; i < q.size() && !ev; i++)
      if (i < 8 || (i >= 44 && i < 96) || i >= 146)
        `CHK(q[i], exp_std(i, pb))
  endtask
  task automatic rej(input logic [47:0] c, input logic lo, input logic [7:0] asc);
    cmd(c, 1'b0, lo, 1'b0);
    `CHK({sts_check, sts_key, sts_asc, q.size() == 0}, {5'h15, asc, 1'b1})
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rr, rd} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial begin
    {nrst, slow, cmd_valid, cmd_port_b, cmd_lun_ok, cmd_ua_pending, cmd_cdb} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {bad_count, check_count} = '0;
    void'($urandom(17));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    axr(8'h00);
    `CHK({rr, rd}, {2'b00, 32'h30303031})
    axr(8'h10);
    `CHK({rr, rd}, {2'b10, 32'h0})
    axw(8'h00, 32'h41424344);
    `CHK(rr, 2'b00)
    axw(8'h10, 32'h0);
    `CHK(rr, 2'b10)
    inq(1'b0, 8'h00, 16'h00FF, 1'b0);
    for (int i = 32; i < 36; i++) `CHK(q[i], 8'(8'h21 + i))
    inq(1'b0, 8'h00, 16'h0007, 1'b1);
    inq(1'b0, 8'h00, 16'h0000, 1'b0);
    inq(1'b1, 8'h00, 16'h00FF, 1'b0);
    for (int i = 5; i < 21; i++) `CHK(q[i] > q[i-1], 1'b1)
    inq(1'b1, 8'h83, 16'h0100, 1'b0);
    rej(cdb(8'h12, 1'b0, 8'h80, 16'h00FF, 8'h00), 1'b1, 8'h24);
    rej(cdb(8'h12, 1'b0, 8'h00, 16'h00FF, 8'h04), 1'b1, 8'h24);
    rej(cdb(8'h12, 1'b1, 8'h81, 16'h00FF, 8'h00), 1'b1, 8'h24);
    rej(cdb(8'h12, 1'b0, 8'h00, 16'h00FF, 8'h00) | 48'h0002_0000_0000, 1'b1, 8'h24);
    rej(cdb(8'h28, 1'b0, 8'h00, 16'h0001, 8'h00), 1'b0, 8'h25);
    cmd(cdb(8'h12, 1'b0, 8'h00, 16'h0008, 8'h00), 1'b0, 1'b0, 1'b1);
    `CHK({q[0], sts_check, sts_ua_kept}, {8'h60, 2'b01})
    cmd(cdb(8'h03, 1'b0, 8'h00, 16'h0012, 8'h00), 1'b0, 1'b0, 1'b0);
    `CHK(fwd, 1'b1)
    axw(8'h04, 32'h0);
    inq(1'b0, 8'h00, 16'h00FF, 1'b0);
    for (int i = 36; i < 44; i++) `CHK(q[i], 8'h20)
    axw(8'h04, 32'h1);
    slow <= 1'b1;
    repeat (24) inq(1'($urandom_range(1)), 8'h00, 16'($urandom_range(170)),
      1'($urandom_range(1)));
    stop_test();
  end
endmodule
`default_nettype wire
